// [rtl/csad_cfg.svh]
/*
  timing counts, field positions and reset values for the core store address decode
  block. assumes a 100 mhz system clock and a synchronous active-low reset.
*/
// Notes on behaviour
// - data strobe issued 750-900 ns into read
// - machine reset returns all control latches
// - report read cycle in progress
// - report write cycle in progress
// - split address into drive, gate, clock fields
// - read starts first unit clock without hint
// - write starts unit chosen by high bit
// - main select latch set by main read
// - x gate is binary of low bits 4-7
// - x driver from read-1 pulse and bits 2-3
// - timing pulses routed by high bits 1-2
// - four always-on sense sets per unit
// - sense strobe gated to selected 8k block
// - write drives x, y and inhibit lines
// - read call starts clock in read mode
// - hint at read call starts second unit
// - inhibit drivers on only for zero bits
`ifndef CSAD_CFG_SVH
`define CSAD_CFG_SVH

// ==========================================================
// timing
// ==========================================================
`define CSAD_CLK_NS        10
`define CSAD_CYCLE_NS      1500
`define CSAD_RD1_NS        100
`define CSAD_RD2_NS        200
`define CSAD_STROBE_BEG_NS 525
`define CSAD_STROBE_END_NS 800
`define CSAD_READY_BEG_NS  750
`define CSAD_READY_END_NS  900
`define CSAD_INH_BEG_NS    300
`define CSAD_INH_END_NS    900
// least times round up, longest round down
`define CSAD_CYC(ns)       (((ns) + `CSAD_CLK_NS - 1) / `CSAD_CLK_NS)
`define CSAD_CYC_DN(ns)    ((ns) / `CSAD_CLK_NS)

// ==========================================================
// address field positions (bit 15 is high bit 0)
// ==========================================================
`define CSAD_HB_CLOCK      15
`define CSAD_HB_BLK_HI     14
`define CSAD_HB_BLK_LO     13
`define CSAD_YDRV_HI       12
`define CSAD_YDRV_LO       10
`define CSAD_YGATE_HI      9
`define CSAD_YGATE_LO      6
`define CSAD_XDRV_HI       5
`define CSAD_XDRV_LO       4
`define CSAD_XGATE_HI      3
`define CSAD_XGATE_LO      0
`define CSAD_CNT_RST       8'h00
`endif

// [rtl/csad_core.sv]
/*
  control and address decode of one 32k core store unit pair facing the processor.
  assumes the processor holds the address from read through write and that
  read and write calls are one-cycle pulses on the 100 mhz system clock.
*/
`timescale 1ns/10ps
`include "csad_cfg.svh"

module csad_core
  import csad_pkg::*;
#(
  parameter int CYCLE_CYC = `CSAD_CYC(`CSAD_CYCLE_NS)  // storage cycle length
) (
  input  wire logic        i_clk_sys,      // system clock
  input  wire logic        i_rst_n,        // machine reset, active low
  input  wire logic        i_read_call,    // read call pulse
  input  wire logic        i_write_call,   // write call pulse
  input  wire logic        i_early_upper_unit_hint, // early high-bit hint
  input  wire logic        i_local_sel,    // read addresses local storage
  input  wire logic        i_src_is_mem,   // data register source is memory
  input  wire logic [15:0] i_storage_address_latch, // held address
  input  wire logic [8:0]  i_store_bits,   // byte to store, parity high
  input  wire logic [8:0]  i_sense_bits,   // final sense amplifier output
  output logic             o_read_echo,    // read cycle in progress
  output logic             o_write_echo,   // write cycle in progress
  output logic             o_data_ready,   // data strobe
  output logic [8:0]       o_data,         // byte loaded by strobe
  output logic             o_use_main,     // main storage select latch
  output logic [1:0]       o_clk_run,      // unit clock running
  output logic [3:0]       o_sense_strobe, // per-8k-block strobe
  output logic [3:0]       o_x_phase,      // x driver set enables
  output logic             o_y_phase,      // y driver half select
  output logic [1:0]       o_x_drv,        // x driver decode
  output logic [3:0]       o_x_gate,       // x gate decode
  output logic [2:0]       o_y_drv,        // y driver decode
  output logic [3:0]       o_y_gate,       // y gate decode
  output logic [8:0]       o_inhibit,      // inhibit driver on
  output logic [1:0]       o_inh_half      // inhibit set select
);

  // ==========================================================
  // timing counts
  // ==========================================================
  localparam logic [7:0] RD1_C   = 8'(`CSAD_CYC(`CSAD_RD1_NS));
  localparam logic [7:0] RD2_C   = 8'(`CSAD_CYC(`CSAD_RD2_NS));
  localparam logic [7:0] STB_B   = 8'(`CSAD_CYC(`CSAD_STROBE_BEG_NS));
  localparam logic [7:0] STB_E   = 8'(`CSAD_CYC_DN(`CSAD_STROBE_END_NS));
  localparam logic [7:0] RDY_B   = 8'(`CSAD_CYC(`CSAD_READY_BEG_NS));
  localparam logic [7:0] RDY_E   = 8'(`CSAD_CYC_DN(`CSAD_READY_END_NS));
  localparam logic [7:0] INH_B   = 8'(`CSAD_CYC(`CSAD_INH_BEG_NS));
  localparam logic [7:0] INH_E   = 8'(`CSAD_CYC_DN(`CSAD_INH_END_NS));
  localparam logic [7:0] LAST_C  = 8'(CYCLE_CYC - 1);

  csad_state_s st_reg;   // registered state
  csad_state_s st_next;  // next state

  // block field, count and run flag
  logic [1:0] blk;       // 8k block within unit
  logic [7:0] c;         // current count
  logic       run;       // cycle active
  assign blk = i_storage_address_latch[`CSAD_HB_BLK_HI:`CSAD_HB_BLK_LO];
  assign c   = st_reg.cnt;
  assign run = (st_reg.mode != CSAD_IDLE);

  // ==========================================================
  // next state: cycle start, decode, timing pulses
  // ==========================================================
  always_comb begin
    st_next = st_reg;
    st_next.ready   = 1'b0;
    st_next.strobe  = 4'h0;
    st_next.xphase  = 4'h0;
    st_next.inhibit = 9'h000;
    case (st_reg.mode)
      CSAD_IDLE: begin
        st_next.cnt = `CSAD_CNT_RST;
        if (i_read_call) begin
          // read call starts the clock in read mode
          st_next.mode    = CSAD_READ;
          st_next.rd_echo = 1'b1;
          // hint picks second unit, absent picks first
          st_next.unit2   = i_early_upper_unit_hint;
          st_next.clk_run = i_early_upper_unit_hint ? 2'b10 : 2'b01;
          // latch follows read target, writes leave it alone
          st_next.use_main = ~i_local_sel;
        end else if (i_write_call) begin
          // unit chosen by the high address bit itself
          st_next.mode    = CSAD_WRITE;
          st_next.wr_echo = 1'b1;
          st_next.unit2   = i_storage_address_latch[`CSAD_HB_CLOCK];
          st_next.clk_run = i_storage_address_latch[`CSAD_HB_CLOCK] ? 2'b10 : 2'b01;
        end
      end
      CSAD_READ, CSAD_WRITE: begin
        st_next.cnt = c + 8'h01;
        // data strobe window, load only when source is memory
        if (st_reg.mode == CSAD_READ && c >= RDY_B && c < RDY_E) begin
          st_next.ready = 1'b1;
          if (i_src_is_mem) begin
            st_next.rdata = i_sense_bits;
          end
        end
        // sense strobe reaches only the addressed block
        if (st_reg.mode == CSAD_READ && c >= STB_B && c < STB_E) begin
          st_next.strobe = 4'(4'h1 << blk);
        end
        // timing pulses steered by block bits and main select
        if (c >= RD1_C && c < INH_E && st_reg.use_main) begin
          st_next.xphase = 4'(4'h1 << blk);
        end
        // inhibit on for zero bits only, during writes
        if (st_reg.mode == CSAD_WRITE && c >= INH_B && c < INH_E) begin
          st_next.inhibit = ~i_store_bits;
        end
        if (c == LAST_C) begin
          st_next.mode    = CSAD_IDLE;
          st_next.rd_echo = 1'b0;
          st_next.wr_echo = 1'b0;
          st_next.clk_run = 2'b00;
        end
      end
      default: begin
        st_next.mode = CSAD_IDLE;
      end
    endcase
    // address field decode, held steady by the processor
    st_next.xgate    = i_storage_address_latch[`CSAD_XGATE_HI:`CSAD_XGATE_LO];
    st_next.xdrv     = i_storage_address_latch[`CSAD_XDRV_HI:`CSAD_XDRV_LO];
    st_next.ydrv     = i_storage_address_latch[`CSAD_YDRV_HI:`CSAD_YDRV_LO];
    st_next.ygate    = i_storage_address_latch[`CSAD_YGATE_HI:`CSAD_YGATE_LO];
    // y driver half on from read-2 time while block bit 14 is low
    st_next.yphase   = run && c >= RD2_C && ~blk[1];
    st_next.inh_half = 2'(2'h1 << i_storage_address_latch[`CSAD_XDRV_HI]);
  end

  // ==========================================================
  // state register; reset clears every latch
  // ==========================================================
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs straight from flops
  assign o_read_echo    = st_reg.rd_echo;
  assign o_write_echo   = st_reg.wr_echo;
  assign o_data_ready   = st_reg.ready;
  assign o_data         = st_reg.rdata;
  assign o_use_main     = st_reg.use_main;
  assign o_clk_run      = st_reg.clk_run;
  assign o_sense_strobe = st_reg.strobe;
  assign o_x_phase      = st_reg.xphase;
  assign o_y_phase      = st_reg.yphase;
  assign o_x_drv        = st_reg.xdrv;
  assign o_x_gate       = st_reg.xgate;
  assign o_y_drv        = st_reg.ydrv;
  assign o_y_gate       = st_reg.ygate;
  assign o_inhibit      = st_reg.inhibit;
  assign o_inh_half     = st_reg.inh_half;

  // ==========================================================
  // assertions
  // ==========================================================
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);

  sequence s_read_start;
    !run && i_read_call;
  endsequence

  a_ready_window: assert property (o_data_ready |-> o_read_echo)
    else $error("data ready outside read cycle");
  // call taken at edge 0, count 75 is seen at edge 76, so the pulse shows from edge 77 on
  a_ready_time: assert property (s_read_start |-> ##77 o_data_ready)
    else $error("data ready not at 770 ns");
  a_reset_clear: assert property ($past(!i_rst_n) |-> !o_read_echo && !o_write_echo)
    else $error("latch not cleared by reset");
  a_read_echo: assert property (s_read_start |=> o_read_echo && !o_write_echo)
    else $error("read echo missing");
  a_write_echo: assert property (!run && !i_read_call && i_write_call |=> o_write_echo)
    else $error("write echo missing");
  a_unit_pick: assert property (s_read_start and !i_early_upper_unit_hint |=> o_clk_run == 2'b01)
    else $error("wrong unit on read");
  a_unit_hint: assert property (s_read_start and i_early_upper_unit_hint |=> o_clk_run == 2'b10)
    else $error("hint ignored");
  a_write_unit: assert property (!run && !i_read_call && i_write_call
      |=> o_clk_run[1] == $past(i_storage_address_latch[15]))
    else $error("wrong unit on write");
  a_main_hold: assert property (st_reg.mode == CSAD_WRITE |-> $stable(o_use_main))
    else $error("main select moved in write");
  a_xgate_dec: assert property (o_x_gate == $past(i_storage_address_latch[3:0]))
    else $error("x gate decode wrong");
  a_strobe_one: assert property ($onehot0(o_sense_strobe))
    else $error("strobe to several blocks");
  a_inhibit_rd: assert property (o_inhibit != 9'h000 |-> o_write_echo)
    else $error("inhibit outside write");

  // ==========================================================
  // further checks on decode and steering
  // ==========================================================
  // the decodes are plain copies of address fields, one cycle late;
  // a slip of one bit position here would address the wrong core line
  // without any other symptom, so every field is watched on its own

  // x driver group from low bits 2-3
  a_xdrv_dec: assert property (o_x_drv == $past(i_storage_address_latch[5:4]))
    else $error("x driver decode wrong");

  // y driver from high bits 3-5
  a_ydrv_dec: assert property (o_y_drv == $past(i_storage_address_latch[12:10]))
    else $error("y driver decode wrong");

  // y gate from high bits 6-7 and low bits 0-1
  a_ygate_dec: assert property (o_y_gate == $past(i_storage_address_latch[9:6]))
    else $error("y gate decode wrong");

  // x phase pulses only reach the array when main storage is in use
  a_phase_main: assert property (o_x_phase != 4'h0 |-> o_use_main)
    else $error("x phase without main select");

  // and only the block named by high bits 1-2
  a_phase_blk: assert property (o_x_phase != 4'h0 |-> o_x_phase == 4'(4'h1 << $past(blk)))
    else $error("x phase to wrong block");

  // the strobe goes to the addressed block and no other
  a_strobe_blk: assert property (o_sense_strobe != 4'h0 |-> o_sense_strobe == 4'(4'h1 << $past(blk)))
    else $error("strobe to wrong block");

  // amplifiers run all the time; only a read strobes them
  a_strobe_rd: assert property (o_sense_strobe != 4'h0 |-> o_read_echo)
    else $error("strobe outside read");

  // inhibit drivers carry the inverse of the byte being stored
  a_inhibit_val: assert property (o_inhibit != 9'h000 |-> o_inhibit == ~$past(i_store_bits))
    else $error("inhibit pattern wrong");

  // exactly one inhibit set is picked once out of reset
  a_inh_half: assert property ($past(i_rst_n) |-> $onehot(o_inh_half))
    else $error("inhibit set select not one-hot");

  // a read of main storage sets the select latch
  a_main_set: assert property (s_read_start and !i_local_sel |=> o_use_main)
    else $error("main select not set");

  // a read of local storage clears it
  a_main_clr: assert property (s_read_start and i_local_sel |=> !o_use_main)
    else $error("main select not cleared");

  // the two echoes never stand together; the processor relies on that
  // to decide which cycle it may follow with
  a_echo_excl: assert property (!(o_read_echo && o_write_echo))
    else $error("read and write echo together");

  // a running cycle always has exactly one unit clock going
  a_clk_one: assert property (o_read_echo || o_write_echo |-> $onehot(o_clk_run))
    else $error("unit clock not one-hot");

endmodule

// [rtl/csad_pkg.sv]
/*
  types for the core store address decode block.
  assumes csad_cfg.svh supplies the numbers.
*/
package csad_pkg;
  // storage clock phase
  typedef enum logic [1:0] {
    CSAD_IDLE,
    CSAD_READ,
    CSAD_WRITE
  } csad_mode_e;

  // whole state of the block
  typedef struct packed {
    csad_mode_e  mode;       // current cycle kind
    logic [7:0]  cnt;        // cycles into storage cycle
    logic        unit2;      // second unit chosen by last call
    logic        use_main;   // main storage select latch
    logic        rd_echo;    // read echo to processor
    logic        wr_echo;    // write echo to processor
    logic        ready;      // data strobe to processor
    logic [8:0]  rdata;      // byte loaded by strobe
    logic [1:0]  clk_run;    // per-unit clock run
    logic [3:0]  strobe;     // per-8k-block sense strobe
    logic [1:0]  xdrv;       // x driver group select
    logic [3:0]  xgate;      // x gate select
    logic [2:0]  ydrv;       // y driver select
    logic [3:0]  ygate;      // y gate select
    logic [3:0]  xphase;     // x driver sets, one per 8k block
    logic        yphase;     // y driver set (read2 vs write2 half)
    logic [8:0]  inhibit;    // inhibit driver enables
    logic [1:0]  inh_half;   // inhibit set select (low/high 4k)
  } csad_state_s;
endpackage

// [test/csad_proc_model.sv]
/*
  processor memory-control model: raises read and write calls and holds the address.
  assumes the storage block samples calls on the rising system clock edge.
*/
`timescale 1ns/10ps

module csad_proc_model (
  input  wire logic        i_clk_sys,    // system clock
  output logic             o_read_call,  // read call pulse
  output logic             o_write_call, // write call pulse
  output logic             o_hint,       // early upper unit hint
  output logic [15:0]      o_addr        // held address
);
  // ==========================================================
  // call sequencing
  // ==========================================================
  // quiet lines until the first call
  initial begin
    o_read_call  = 1'b0;
    o_write_call = 1'b0;
    o_hint       = 1'b0;
    o_addr       = 16'h0000;
  end

  // read: new address and hint travel with the call
  task automatic rd(input logic [15:0] a, input logic h);
    @(posedge i_clk_sys);
    #1;
    o_addr      = a;
    o_hint      = h;
    o_read_call = 1'b1;
    @(posedge i_clk_sys);
    #1;
    o_read_call = 1'b0;
    o_hint      = 1'b0; // hint is never raised outside a read call
  endtask

  // write: address untouched so the byte returns to the place just read
  task automatic wr();
    @(posedge i_clk_sys);
    #1;
    o_write_call = 1'b1;
    @(posedge i_clk_sys);
    #1;
    o_write_call = 1'b0;
  endtask
endmodule

// [test/tb_top.sv]
/*
  self-checking bench for csad_core: random read/write pairs plus corner cases.
  assumes the processor model drives calls and address; bench drives the rest.
*/
`timescale 1ns/10ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin err_total++; $display("ERROR %0t got %h exp %h", $time, a, b); end end

module tb_top;
  // ==========================================================
  // signals
  // ==========================================================
  localparam int CYC = 100;           // shortened storage cycle
  logic        clk, rst_n, loc, src;  // clock, reset, local, source
  logic [8:0]  store, sense, sns;     // store byte, sense byte, sense line
  logic        rc, wc, hint;          // calls from the processor model
  logic [15:0] addr;                  // held address
  logic        re, we, rdy, um, yp;   // echoes, strobe, main select
  logic [8:0]  dat, inh, exp_d;       // loaded byte, inhibit, expected byte
  logic [1:0]  cr, xd, ih;            // clock run, x driver, inhibit half
  logic [3:0]  ss, xp, xg, yg;        // strobes, x phase, gates
  logic [2:0]  yd;                    // y driver
  logic [31:0] r;                     // random draw
  int          err_total, n_tests;    // verdict counters

  csad_proc_model u_proc (.i_clk_sys(clk), .o_read_call(rc), .o_write_call(wc), .o_hint(hint), .o_addr(addr));
  csad_core #(.CYCLE_CYC(CYC)) u_dut (
    .i_clk_sys(clk), .i_rst_n(rst_n), .i_read_call(rc), .i_write_call(wc),
    .i_early_upper_unit_hint(hint), .i_local_sel(loc), .i_src_is_mem(src),
    .i_storage_address_latch(addr), .i_store_bits(store), .i_sense_bits(sns),
    .o_read_echo(re), .o_write_echo(we), .o_data_ready(rdy), .o_data(dat), .o_use_main(um),
    .o_clk_run(cr), .o_sense_strobe(ss), .o_x_phase(xp), .o_y_phase(yp), .o_x_drv(xd),
    .o_x_gate(xg), .o_y_drv(yd), .o_y_gate(yg), .o_inhibit(inh), .o_inh_half(ih));

  // ==========================================================
  // tasks
  // ==========================================================
  // step n edges, then settle past the edge
  task automatic tk(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // read then write at one address; a write call inside the read is refused
  task automatic rw(input logic [15:0] a, input logic h, input logic l, input logic s);
    loc   = l;
    src   = s;
    sense = 9'($urandom);
    store = 9'($urandom);
    sns   = ~sense; // line shows junk until the strobe and after the ready window
    u_proc.rd(a, h);
    tk(1);
    `CHK(re, 1'b1)
    `CHK(cr, h ? 2'h2 : 2'h1)
    `CHK(um, ~l)
    `CHK({xg, xd, yd, yg}, {a[3:0], a[5:4], a[12:10], a[9:6]})
    u_proc.wr();
    tk(2);
    `CHK({re, we}, 2'h2)
    tk(48);
    sns = sense;
    tk(1);
    `CHK(ss, 4'h1 << {a[14], a[13]})
    `CHK(xp & {4{l}}, 4'h0)
    tk(21);
    `CHK(rdy, 1'b0)
    tk(1);
    `CHK(rdy, 1'b1)
    tk(1);
    if (s) exp_d = sense;
    `CHK(dat, exp_d)
    tk(3);
    `CHK(ss, 4'h1 << {a[14], a[13]})
    tk(1);
    `CHK(ss, 4'h0)
    tk(9);
    `CHK(rdy, 1'b1)
    tk(1);
    `CHK(rdy, 1'b0)
    sns = ~sense; // junk again only once the ready window is over
    tk(CYC - 92);
    `CHK(re, 1'b1)
    tk(1);
    `CHK(re, 1'b0)
    u_proc.wr();
    tk(1);
    `CHK(we, 1'b1)
    `CHK(cr, a[15] ? 2'h2 : 2'h1)
    `CHK(um, ~l)
    tk(29);
    `CHK(inh, 9'h000)
    tk(1);
    `CHK(inh, ~store)
    `CHK(ih, 2'h1 << a[5])
    tk(59);
    `CHK(inh, ~store)
    tk(1);
    `CHK(inh, 9'h000)
    tk(CYC - 92);
    `CHK(we, 1'b1)
    tk(1);
    `CHK(we, 1'b0)
  endtask

  // verdict and end of run
  task automatic stop_test;
    if (err_total == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ==========================================================
  // clock, watchdog, main sequence
  // ==========================================================
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // whole run is near 1450 cycles; far past that means a hang
  initial begin
    #500000;
    err_total++;
    stop_test;
  end

  // corner addresses first, then random pairs, then a reset mid-cycle
  initial begin
    rst_n = 1'b0;
    {loc, src, store, sense, sns, exp_d} = '0;
    err_total = 0;
    n_tests = 0;
    void'($urandom(99));
    tk(8);
    rst_n = 1'b1;
    rw(16'h4d8b, 1'b0, 1'b0, 1'b1);
    rw(16'hffff, 1'b1, 1'b1, 1'b0);
    repeat (5) begin
      r = $urandom;
      rw(r[15:0], r[16], r[17], r[18]);
    end
    u_proc.rd(16'h0000, 1'b0);
    tk(5);
    rst_n = 1'b0;
    tk(2);
    `CHK({re, we, cr, um, rdy, dat}, 15'h0000)
    rst_n = 1'b1;
    stop_test;
  end
endmodule
